/* File: rtl/interval_timer_pkg.sv */
package interval_timer_pkg;

  // Counter width and the time base period in clock cycles.
  localparam int unsigned COUNT_WIDTH      = 8;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned TICK_LOW_MIN_NS  = 500;
  localparam int unsigned TICK_LOW_CYCLES  =
    (TICK_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned PERIOD_DEFAULT   = 200;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 8'h00;
  localparam logic [15:0] PHASE_RESET = 16'h0000;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } timer_state_e;

  // One open-drain pin seen from inside the design.
  typedef struct packed {
    logic drive;
    logic level;
  } od_pin_s;

endpackage : interval_timer_pkg

/* File: rtl/programmable_interval_timer.sv */
`timescale 1ns/1ps

// Summary of operation
// - Outputs float after power-up until triggered.
// - Rising trigger edge starts a timing cycle.
// - Trigger starts time base, clears counter.
// - Each tick advances the 8-bit counter.
// - Rising master reset edge ends cycle.
// - Triggers ignored while a cycle runs.
// - Simultaneous trigger and reset: trigger wins in reset state, reset wins while a cycle runs.
// - Reset state stops base, floats outputs.
// - Without feedback the counter wraps forever.
// - Counter steps on tick pin falling edge.
// - Tick pin held low freezes the counter.
// - Tick pin pulses low once per period.
// - Internal tick low pulse exceeds 500 ns.
// - Tick pin accepts an external clock.
// - Timing pin low disables internal ticks.
// - Delay of 1 to 255 by joined outputs.
// - Count outputs are open-drain active low.
// - Joined bus low for more than N-1 and at most N periods.
module programmable_interval_timer #(
  parameter int unsigned PERIOD_CYCLES = interval_timer_pkg::PERIOD_DEFAULT
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       trigger_in,
  input  wire logic       master_reset_in,
  input  wire logic       timing_net_in,
  input  wire logic       tick_in,
  output logic            tick_out_n,
  output logic            tick_oe,
  output logic [7:0]      count_out_n,
  output logic [7:0]      count_oe
);

  localparam int unsigned W = interval_timer_pkg::COUNT_WIDTH;

  logic [2:0]     trigSync;
  logic [2:0]     mrSync;
  logic [2:0]     tickSync;
  logic [1:0]     netSync;
  logic           trigRise;
  logic           mrRise;
  logic           tickFall;
  logic           running;
  logic           baseOn;
  interval_timer_pkg::timer_state_e state_reg;
  interval_timer_pkg::timer_state_e state_next;
  logic [15:0]    phase_reg;
  logic           lowPhase;
  logic [W-1:0]   count_reg;
  logic [W-1:0]   count_next;
  logic [15:0]    lowRun_reg;
  interval_timer_pkg::od_pin_s tickPin_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trigSync <= 3'h0;
      mrSync   <= 3'h0;
      tickSync <= 3'h7;
      netSync  <= 2'h3;
    end else begin
      trigSync <= {trigSync[1:0], trigger_in};
      mrSync   <= {mrSync[1:0], master_reset_in};
      tickSync <= {tickSync[1:0], tick_in};
      netSync  <= {netSync[0], timing_net_in};
    end
  end

  assign trigRise = trigSync[1] & ~trigSync[2];
  assign mrRise   = mrSync[1] & ~mrSync[2];
  assign tickFall = ~tickSync[1] & tickSync[2];
  assign running  = (state_reg == interval_timer_pkg::ST_RUN);
  assign baseOn   = netSync[1];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      interval_timer_pkg::ST_IDLE: begin
        if (trigRise) begin
          state_next = interval_timer_pkg::ST_RUN;
        end
      end
      interval_timer_pkg::ST_RUN: begin
        if (mrRise) begin
          state_next = interval_timer_pkg::ST_IDLE;
        end
      end
      default: state_next = interval_timer_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= interval_timer_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // period counter for the time base
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= interval_timer_pkg::PHASE_RESET;
    end else if (!running || !baseOn || state_next != state_reg) begin
      phase_reg <= interval_timer_pkg::PHASE_RESET;
    end else if (phase_reg == 16'(PERIOD_CYCLES - 1)) begin
      phase_reg <= interval_timer_pkg::PHASE_RESET;
    end else begin
      phase_reg <= phase_reg + 16'h0001;
    end
  end

  // low phase lasts more than 500 ns
  assign lowPhase = (phase_reg >=
    16'(PERIOD_CYCLES - interval_timer_pkg::TICK_LOW_CYCLES));

  // drive tick pin low in low phase
  // otherwise released for an external clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickPin_reg <= '{drive: 1'b0, level: 1'b1};
    end else begin
      tickPin_reg.drive <= running && baseOn && lowPhase &&
                           state_next == state_reg;
      tickPin_reg.level <= 1'b0;
    end
  end
  assign tick_oe    = tickPin_reg.drive;
  assign tick_out_n = tickPin_reg.level;

  // a held-low pin gives no edge
  always_comb begin
    count_next = count_reg;
    if (state_next != interval_timer_pkg::ST_RUN || !running) begin
      count_next = interval_timer_pkg::COUNT_RESET;
    end else if (tickFall && !mrRise) begin
      count_next = count_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= interval_timer_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowRun_reg <= interval_timer_pkg::PHASE_RESET;
    end else if (tick_oe) begin
      lowRun_reg <= lowRun_reg + 16'h0001;
    end else begin
      lowRun_reg <= interval_timer_pkg::PHASE_RESET;
    end
  end

  // open-drain stages, low when bit zero
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_out
      logic drive_reg;
      logic level_reg;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          drive_reg <= 1'b0;
        end else begin
          drive_reg <= (state_next == interval_timer_pkg::ST_RUN) &&
                       !count_next[k];
        end
      end
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          level_reg <= 1'b0;
        end else begin
          level_reg <= 1'b0;
        end
      end
      assign count_oe[k]    = drive_reg;
      assign count_out_n[k] = level_reg;
    end
  endgenerate

  property p_trig_ignored;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && trigRise && !mrRise) |=> running;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored)
    else $error("Trigger disturbed a running cycle.");

  property p_reset_stops;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && mrRise) |=> !running ##1 (count_oe == 8'h00);
  endproperty
  a_reset_stops: assert property (p_reset_stops)
    else $error("Master reset did not end the cycle.");

  property p_trig_wins;
    @(posedge ref_clk) disable iff (!arst_n)
      (!running && trigRise && mrRise) |=> running;
  endproperty
  a_trig_wins: assert property (p_trig_wins)
    else $error("Trigger lost against master reset.");

  property p_start_low;
    @(posedge ref_clk) disable iff (!arst_n)
      (!running && trigRise) |=> ##1 (count_oe == 8'hFF);
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("Outputs not all low after trigger.");

  property p_idle_float;
    @(posedge ref_clk) disable iff (!arst_n)
      (!running && !$past(running)) |-> (count_oe == 8'h00 && !tick_oe);
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("Output driven in reset state.");

  property p_count_step;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && tickFall && !mrRise) |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Counter did not advance on a tick.");

  property p_freeze;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && !tickFall) |=> (!running || count_reg == $past(count_reg));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Counter moved without a tick edge.");

  sequence s_low_start;
    running && !tick_oe ##1 tick_oe;
  endsequence
  property p_low_width;
    @(posedge ref_clk) disable iff (!arst_n)
      s_low_start |-> (tick_oe || !running || !baseOn) [*8];
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("Tick low pulse too short.");

  property p_bits;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && $past(running) && $stable(count_reg))
        |-> (count_oe == ~count_reg);
  endproperty
  a_bits: assert property (p_bits)
    else $error("Output stage does not follow its counter bit.");

  property p_low_run;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && baseOn && $fell(tick_oe)) |->
        (lowRun_reg >= 16'(interval_timer_pkg::TICK_LOW_CYCLES));
  endproperty
  a_low_run: assert property (p_low_run)
    else $error("Tick low pulse shorter than its minimum.");

  property p_tick_idle;
    @(posedge ref_clk) disable iff (!arst_n)
      !running |-> !tick_oe;
  endproperty
  a_tick_idle: assert property (p_tick_idle)
    else $error("Tick pin driven in reset state.");

  property p_base_off;
    @(posedge ref_clk) disable iff (!arst_n)
      !baseOn |=> !tick_oe;
  endproperty
  a_base_off: assert property (p_base_off)
    else $error("Tick pin driven with the time base off.");

  property p_levels;
    @(posedge ref_clk) disable iff (!arst_n)
      running |-> (count_out_n == 8'h00 && !tick_out_n);
  endproperty
  a_levels: assert property (p_levels)
    else $error("Open-drain stage drives a high level.");

  property p_wrap;
    @(posedge ref_clk) disable iff (!arst_n)
      (running && tickFall && !mrRise && count_reg == 8'hFF) |=>
        (count_reg == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Counter did not wrap to zero.");

  property p_idle_count;
    @(posedge ref_clk) disable iff (!arst_n)
      !running |->
        (count_reg == interval_timer_pkg::COUNT_RESET &&
         phase_reg == interval_timer_pkg::PHASE_RESET);
  endproperty
  a_idle_count: assert property (p_idle_count)
    else $error("Counter or time base moved in reset state.");

  property p_trig_sync;
    @(posedge ref_clk) disable iff (!arst_n)
      trigRise |-> $past(trigger_in, 2);
  endproperty
  a_trig_sync: assert property (p_trig_sync)
    else $error("Trigger edge seen without a synchronised high.");

  property p_mr_sync;
    @(posedge ref_clk) disable iff (!arst_n)
      mrRise |-> $past(master_reset_in, 2);
  endproperty
  a_mr_sync: assert property (p_mr_sync)
    else $error("Reset edge seen without a synchronised high.");

  property p_tick_sync;
    @(posedge ref_clk) disable iff (!arst_n)
      tickFall |-> !$past(tick_in, 2);
  endproperty
  a_tick_sync: assert property (p_tick_sync)
    else $error("Tick edge seen without a synchronised low.");

endmodule // programmable_interval_timer

/* File: sim/timer_far_side.sv */
`timescale 1ns/1ps

module timer_far_side (
  input  wire logic       tick_oe,
  input  wire logic [7:0] count_oe,
  input  wire logic       feedback_switch,
  input  wire logic [7:0] feedbackMask,
  input  wire logic       extTickLow,
  input  wire logic       tbReset,
  output wire logic       tick_in,
  output wire logic       master_reset_in,
  output wire logic       busLevel
);
  assign busLevel = ~|(count_oe & feedbackMask);
  assign tick_in = ~(tick_oe | extTickLow);
  assign master_reset_in = feedback_switch ? busLevel : tbReset;
endmodule // timer_far_side

/* File: sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  localparam int unsigned PER = 60;
  logic       ref_clk, arst_n, trigger_in, timing_net_in, tbReset;
  logic       feedback_switch, extTickLow, tick_in, master_reset_in;
  logic       tick_oe, busLevel, tickPrev, tickLevel;
  logic [7:0] countLevel;
  logic [7:0] count_oe, feedbackMask, snap;
  int         num_errors, check_count, seed, cycles, falls, d, t, m;

  programmable_interval_timer #(.PERIOD_CYCLES(PER)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .trigger_in(trigger_in),
    .master_reset_in(master_reset_in), .timing_net_in(timing_net_in),
    .tick_in(tick_in), .tick_out_n(tickLevel), .tick_oe(tick_oe),
    .count_out_n(countLevel), .count_oe(count_oe));

  timer_far_side far_u (
    .tick_oe(tick_oe), .count_oe(count_oe),
    .feedback_switch(feedback_switch), .feedbackMask(feedbackMask),
    .extTickLow(extTickLow), .tbReset(tbReset), .tick_in(tick_in),
    .master_reset_in(master_reset_in), .busLevel(busLevel));

  function automatic logic [7:0] exp_oe(int c);
    return ~c[7:0];
  endfunction

  function automatic logic shot_ok(int n, int dur);
    return dur > (n - 1) * PER && dur <= n * PER;
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // The ceiling allows for the longest runs with room to spare.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    tickPrev <= tick_in;
    if (tickPrev === 1'b1 && tick_in === 1'b0) falls <= falls + 1;
    if (cycles == 90000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic pulse_in(bit trig, bit rst);
    trigger_in = trig;
    tbReset = rst;
    cyc(4);
    trigger_in = 1'b0;
    tbReset = 1'b0;
    cyc(4);
  endtask

  task automatic wait_fall();
    int k;
    k = 0;
    while (tick_in !== 1'b1 && k < 300) begin cyc(1); k++; end
    while (tick_in !== 1'b0 && k < 300) begin cyc(1); k++; end
    cyc(5);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    seed = 31433;
    {arst_n, trigger_in, tbReset, feedback_switch, extTickLow} = '0;
    timing_net_in = 1'b1;
    feedbackMask = 8'h00;
    cyc(16);
    arst_n = 1'b1;
    cyc(4);
    chk("idle", 16'h0000, {tick_oe, count_oe});
    $display("test idle done");
    falls = 0;
    pulse_in(1'b1, 1'b0);
    chk("start", 16'h00FF, {tick_oe, count_oe});
    chk("levels", 16'h0000, {tickLevel, countLevel});
    for (t = 0; t < 270; t++) begin
      wait_fall();
      d = 5;
      while (tick_oe === 1'b1 && d < PER) begin cyc(1); d++; end
      chk("tick_low", 16'h0001, d * 10 > 500);
      chk("count", exp_oe(falls), count_oe);
      if (t == 100) pulse_in(1'b1, 1'b0);
    end
    wait_fall();
    extTickLow = 1'b1;
    snap = count_oe;
    cyc(3 * PER);
    chk("clamp", snap, count_oe);
    extTickLow = 1'b0;
    $display("test freerun done");
    pulse_in(1'b0, 1'b1);
    cyc(2 * PER);
    chk("reset", 16'h0000, {tick_oe, count_oe});
    pulse_in(1'b1, 1'b1);
    chk("both", 16'h00FF, count_oe);
    pulse_in(1'b0, 1'b1);
    $display("test reset done");
    timing_net_in = 1'b0;
    pulse_in(1'b1, 1'b0);
    falls = 0;
    m = 3 + ($unsigned($random(seed)) % 8);
    repeat (m) begin
      extTickLow = 1'b1;
      cyc(6);
      extTickLow = 1'b0;
      cyc(6);
    end
    chk("ext", exp_oe(m), count_oe);
    chk("ext_falls", m, falls);
    pulse_in(1'b0, 1'b1);
    timing_net_in = 1'b1;
    $display("test extclock done");
    feedback_switch = 1'b1;
    for (t = 0; t < 3; t++) begin
      feedbackMask = (t == 0) ? 8'h01 : (t == 1) ? 8'hFF : $random(seed);
      if (feedbackMask == 8'h00) feedbackMask = 8'h05;
      pulse_in(1'b1, 1'b0);
      d = 8;
      while (busLevel === 1'b0 && d < 16000) begin cyc(1); d++; end
      chk("shot", 16'h0001, shot_ok(feedbackMask, d));
      cyc(8);
      chk("self_reset", 16'h0000, count_oe);
    end
    $display("test oneshot done");
    stop_test();
  end
endmodule // tb_top
